// >>> hdl/emulator_probe_reset_sync.sv
/*
 Probe control: reset commands, register buffer, clock phase, bus
 release, sync start hold and trace filtering.
 Assumes inputs synchronous to mclk and a one-cycle-latency register port.
*/
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
module emulator_probe_reset_sync
   import probe_ctrl_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdata,
   input  wire logic        syncStart_n,
   input  wire trace_t      busEvent,
   output logic             procReset,
   output logic             procClk,
   output logic             hold,
   output logic             hlda,
   output logic             busOe,
   output logic             fetchEnable,
   output logic             softwareReload,
   output logic             extensionReset,
   output trace_t           traceWord
);
   // ********************************************
   // State
   // ********************************************
   mode_t       mode;
   logic [4:0]  options;
   logic [15:0] liveReg [NREG];
   logic [15:0] bufReg  [NREG];
   logic [15:0] snapReg [NREG];
   logic [3:0]  resetCnt;
   logic        highAddr;
   logic        syncMeta;
   logic        syncSeen;
   logic        syncHold;
   logic        reloading;
   logic [3:0]  reloadIdx;
   logic [31:0] bpOut;
   logic        bpRefused;
   logic [3:0]  regSel;
   logic [2:0]  cmd;
   logic        cmdValid;

   assign cmd = regWdata[2:0];
   assign cmdValid = clkEn && regWr && regAddr == ADDR_COMMAND;

   function automatic logic [15:0] reset_value(input logic [3:0] idx);
      if (idx == R_CS)
         return RST_CS;
      if (idx == R_INSTR_PTR)
         return RST_INSTR_PTR;
      return RST_GP;
   endfunction

   function automatic logic is_reg_reset(input logic [2:0] c);
      return c == CMD_RESET_REGS || c == CMD_RESET_FULL;
   endfunction

   // Translate segment:offset; real mode yields a 20-bit address
   function automatic logic [23:0] translate(input logic [31:0] a,
                                             input logic sel);
      logic [23:0] p;
      p = (sel || a[BP_ABSOLUTE]) ? a[23:0]
          : {4'h0, 20'({2'b00, a[29:16], 4'h0} + {4'h0, a[15:0]})};
      if (a[BP_OVERRIDE])
         p[23:20] = HIGH_NIBBLE;
      return p;
   endfunction

   // ********************************************
   // Reset pulse and processor clock
   // ********************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         resetCnt  <= 4'(RESET_CYC);
         procReset <= 1'b1;
      end else if (clkEn) begin
         if (cmdValid && (cmd == CMD_RESET_UNIT || is_reg_reset(cmd))) begin
            resetCnt  <= 4'(RESET_CYC);
            procReset <= 1'b1;
         end else if (resetCnt != 4'h0) begin
            resetCnt <= resetCnt - 4'h1;
         end else begin
            procReset <= 1'b0;
         end
      end
   end

   // Extension is left alone; the prototype must reset it itself
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         extensionReset <= 1'b0;
      else if (clkEn)
         extensionReset <= 1'b0;
   end

   // Divider restarts on RESET release, so phase follows our RESET only
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         procClk <= 1'b0;
      else if (clkEn) begin
         if (procReset)
            procClk <= 1'b0;
         else
            procClk <= ~procClk;
      end
   end

   // ********************************************
   // Options
   // ********************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         options <= OPT_DEFAULT;
      else if (clkEn) begin
         if (cmdValid && cmd == CMD_RESET_FULL)
            options <= OPT_DEFAULT;
         else if (regWr && regAddr == ADDR_OPTIONS)
            options <= regWdata[4:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         softwareReload <= 1'b0;
      else if (clkEn)
         softwareReload <= cmdValid && cmd == CMD_RESET_FULL;
   end

   // ********************************************
   // Mode and register buffer
   // ********************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         mode <= ST_INTERROGATE;
      else if (clkEn && cmdValid) begin
         if (cmd == CMD_GO && !reloading)
            mode <= ST_EMULATE;
         else if (cmd == CMD_BREAK || is_reg_reset(cmd)
                  || cmd == CMD_RESET_UNIT)
            mode <= ST_INTERROGATE;
      end
   end

   // Resume reload walks one register a cycle; fetch waits for it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reloading <= 1'b0;
         reloadIdx <= 4'h0;
      end else if (clkEn) begin
         if (cmdValid && cmd == CMD_GO && mode == ST_INTERROGATE) begin
            reloading <= 1'b1;
            reloadIdx <= 4'h0;
         end else if (reloading) begin
            reloadIdx <= reloadIdx + 4'h1;
            if (reloadIdx == 4'(NREG - 1))
               reloading <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         fetchEnable <= 1'b0;
      else if (clkEn)
         fetchEnable <= mode == ST_EMULATE && !reloading
                        && !procReset && !syncHold;
   end

   always_ff @(posedge mclk) begin
      if (clkEn) begin
         for (int i = 0; i < NREG; i++) begin
            if (cmdValid && is_reg_reset(cmd)) begin
               if (cmd == CMD_RESET_FULL || i >= int'(R_ES))
                  liveReg[i] <= reset_value(4'(i));
               if (cmd == CMD_RESET_FULL || i >= int'(R_ES))
                  bufReg[i] <= reset_value(4'(i));
            end else if (cmdValid && cmd == CMD_RESET_UNIT
                         && mode == ST_EMULATE) begin
               liveReg[i] <= snapReg[i];
               bufReg[i]  <= snapReg[i];
            end else if (cmdValid && cmd == CMD_BREAK
                         && mode == ST_EMULATE) begin
               bufReg[i] <= liveReg[i];
            end else if (cmdValid && cmd == CMD_GO
                         && mode == ST_INTERROGATE) begin
               snapReg[i] <= bufReg[i];
            end
            // Unit reset while interrogating leaves the buffer alone
         end
         if (reloading)
            liveReg[reloadIdx] <= bufReg[reloadIdx];
         if (regWr && regAddr == ADDR_REGDAT && mode == ST_INTERROGATE
             && !reloading)
            bufReg[regSel] <= regWdata[15:0];
      end
   end

   // A23-A20 stay high from reset until CS is written
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         highAddr <= 1'b1;
      else if (clkEn) begin
         if (cmdValid && is_reg_reset(cmd))
            highAddr <= 1'b1;
         else if (regWr && regAddr == ADDR_REGDAT && regSel == R_CS)
            highAddr <= 1'b0;
      end
   end

   // ********************************************
   // Breakpoint address
   // ********************************************
   // Status word protection bit is never consulted here
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bpOut     <= 32'h0000_0000;
         bpRefused <= 1'b0;
      end else if (clkEn && regWr && regAddr == ADDR_BPIN) begin
         if (regWdata[BP_ABSOLUTE] && options[OPT_SEL] && options[OPT_PCHK])
            bpRefused <= 1'b1;
         else begin
            bpRefused <= 1'b0;
            bpOut <= {8'h00,
                      translate(regWdata, options[OPT_SEL])};
         end
      end
   end

   // ********************************************
   // Sync start hold
   // ********************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         syncMeta <= 1'b1;
         syncSeen <= 1'b1;
      end else if (clkEn && procClk) begin
         syncMeta <= syncStart_n;
         syncSeen <= syncMeta;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         syncHold <= 1'b0;
      else if (clkEn) begin
         if (cmdValid && cmd == CMD_GO && !syncSeen)
            syncHold <= 1'b1;
         else if (syncSeen)
            syncHold <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hold  <= 1'b0;
         hlda  <= 1'b0;
         busOe <= 1'b0;
      end else if (clkEn) begin
         hold  <= syncHold;
         hlda  <= 1'b0;
         busOe <= !procReset && !syncHold && !(cmdValid
                  && (cmd == CMD_RESET_UNIT || is_reg_reset(cmd)));
      end
   end

   // ********************************************
   // Trace filter
   // ********************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         traceWord <= '0;
      else if (clkEn) begin
         traceWord <= busEvent;
         traceWord.valid <= busEvent.valid && !busEvent.coproc
                            && !busEvent.cascade;
      end
   end

   // ********************************************
   // Register read port
   // ********************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= 32'h0000_0000;
         regSel   <= 4'h0;
      end else if (clkEn) begin
         if (regWr && regAddr == ADDR_REGSEL)
            regSel <= regWdata[3:0];
         regRdata <= 32'h0000_0000;
         if (regRd) begin
            unique case (regAddr)
               ADDR_OPTIONS: regRdata <= {27'h0, options};
               ADDR_STATUS:  regRdata <= {26'h0, bpRefused, highAddr,
                  syncHold, reloading, procReset, mode == ST_EMULATE};
               ADDR_BPOUT:   regRdata <= bpOut;
               ADDR_REGSEL:  regRdata <= {28'h0, regSel};
               ADDR_REGDAT:  regRdata <= {16'h0, bufReg[regSel]};
               default:      regRdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ********************************************
   // Checks
   // ********************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   AST_RESET_PULSE: assert property (
      cmdValid && cmd == CMD_RESET_REGS |=> procReset)
      else $error("reset command did not assert RESET");
   AST_BUS_OFF_IN_RESET: assert property (
      procReset |-> !busOe)
      else $error("bus driven during reset");
   AST_CLK_ALIGN: assert property (
      clkEn && procReset ##1 clkEn && !procReset |=> procClk == 1'b1)
      else $error("clock phase not aligned to reset");
   AST_SYNC_HOLD: assert property (
      syncHold |=> hold && !hlda)
      else $error("hold missing for sync start");
   AST_TRACE_CASCADE: assert property (
      clkEn && busEvent.cascade |=> !traceWord.valid)
      else $error("cascade address traced");
   AST_FULL_DEFAULTS: assert property (
      cmdValid && cmd == CMD_RESET_FULL |=> options == OPT_DEFAULT)
      else $error("options not defaulted");
   AST_FETCH_WAIT: assert property (
      reloading |=> !fetchEnable)
      else $error("fetch during reload");
   AST_HIGH_ADDR: assert property (
      cmdValid && cmd == CMD_RESET_REGS |=> highAddr)
      else $error("high address bits not set");
endmodule

// >>> hdl/probe_ctrl_pkg.sv
/*
 Shared constants and carrier types for the emulation probe control block.
 Assumes a single 50 MHz clock and a plain strobe register port.
*/
package probe_ctrl_pkg;
   // ********************************************
   // Register map (byte addresses)
   // ********************************************
   localparam logic [7:0] ADDR_COMMAND = 8'h00;
   localparam logic [7:0] ADDR_OPTIONS = 8'h04;
   localparam logic [7:0] ADDR_STATUS  = 8'h08;
   localparam logic [7:0] ADDR_BPIN    = 8'h0C;
   localparam logic [7:0] ADDR_BPOUT   = 8'h10;
   localparam logic [7:0] ADDR_REGSEL  = 8'h14;
   localparam logic [7:0] ADDR_REGDAT  = 8'h18;
   localparam logic [7:0] ADDR_TRACE   = 8'h1C;
   // ********************************************
   // Command codes
   // ********************************************
   localparam logic [2:0] CMD_RESET_UNIT = 3'h1;
   localparam logic [2:0] CMD_RESET_REGS = 3'h2;
   localparam logic [2:0] CMD_RESET_FULL = 3'h3;
   localparam logic [2:0] CMD_GO         = 3'h4;
   localparam logic [2:0] CMD_BREAK      = 3'h5;
   // ********************************************
   // Option bit positions and defaults
   // ********************************************
   localparam int OPT_SEL    = 0;
   localparam int OPT_PCHK   = 1;
   localparam int OPT_USER_RESET_EN = 2;
   localparam int OPT_BUS_TIMEOUT   = 3;
   localparam int OPT_READY_TIMEOUT = 4;
   localparam logic [4:0] OPT_DEFAULT = 5'h1E;
   localparam int BP_OVERRIDE = 31;
   localparam int BP_ABSOLUTE = 30;
   // ********************************************
   // Register buffer layout
   // ********************************************
   localparam int NREG = 16;
   localparam logic [3:0] R_AX = 4'h0;
   localparam logic [3:0] R_SP = 4'h4;
   localparam logic [3:0] R_ES = 4'h8;
   localparam logic [3:0] R_CS = 4'h9;
   localparam logic [3:0] R_SS = 4'hA;
   localparam logic [3:0] R_DS = 4'hB;
   localparam logic [3:0] R_INSTR_PTR = 4'hC;
   localparam logic [3:0] R_STATUS_WORD = 4'hD;
   localparam logic [15:0] RST_CS = 16'hF000;
   localparam logic [15:0] RST_INSTR_PTR = 16'hFFF0;
   localparam logic [15:0] RST_GP = 16'h0000;
   localparam logic [23:0] RST_VECTOR = 24'hFFFFF0;
   localparam logic [3:0] HIGH_NIBBLE = 4'hF;
   // ********************************************
   // Timing
   // ********************************************
   localparam int CLK_MHZ   = 50;
   localparam int RESET_NS  = 200;
   localparam int RESET_CYC = (RESET_NS * CLK_MHZ + 999) / 1000;
   typedef enum {ST_INTERROGATE, ST_EMULATE} mode_t;
   typedef struct packed {
      logic [23:0] addr;
      logic        drive;
   } bus_t;
   typedef struct packed {
      logic        valid;
      logic        extension;
      logic        cascade;
      logic        coproc;
      logic [23:0] addr;
   } trace_t;
endpackage

// >>> verification/target_model.sv
/*
 Behavioural stand-in for the user prototype: sync start pin and bus events.
 Assumes the bench hands it random words and a start hold request.
*/
`timescale 1ns/10ps
module target_model
   import probe_ctrl_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        startLow,
   input  wire logic [31:0] evRnd,
   input  wire logic        procReset,
   output logic             syncStart_n,
   output trace_t           busEvent,
   output logic             extResetReq
);
   // ********************************************
   // Prototype side
   // ********************************************
   // Pulled up, so it reads high whenever nobody holds it low
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         syncStart_n <= 1'b1;
      end else begin
         syncStart_n <= ~startLow;
      end
   end
   always_ff @(posedge mclk) begin
      busEvent <= trace_t'(evRnd[27:0]);
   end
   // Own processor clock free-runs off mclk, never follows RESET, so
   // a probe reset cannot drag the prototype into bus contention
   logic targetClk;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         targetClk <= 1'b0;
      end else begin
         targetClk <= ~targetClk;
      end
   end
   // Prototype resets the numeric extension with the processor
   assign extResetReq = procReset;
endmodule

// >>> verification/testbench.sv
/*
 Self-checking bench for the probe control block.
 Assumes the target model supplies sync start and random bus events.
*/
`timescale 1ns/10ps
module testbench;
   import probe_ctrl_pkg::*;
   logic        mclk, rst_n, clkEn, regWr, regRd, startLow;
   logic [7:0]  regAddr;
   logic [31:0] regWdata, regRdata, rnd, evRnd, d, bp;
   logic        procReset, procClk, hold, hlda, busOe, a;
   logic        fetchEnable, softwareReload, extensionReset, syncStart_n;
   trace_t      busEvent, traceWord, prevEv;
   int          error_cnt, tests_run, n, m, i;
   // ********************************************
   // Clock, instances, helpers
   // ********************************************
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   emulator_probe_reset_sync dut_u (.mclk(mclk), .rst_n(rst_n),
      .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .syncStart_n(syncStart_n), .busEvent(busEvent),
      .procReset(procReset), .procClk(procClk), .hold(hold),
      .hlda(hlda), .busOe(busOe), .fetchEnable(fetchEnable),
      .softwareReload(softwareReload),
      .extensionReset(extensionReset), .traceWord(traceWord));
   target_model partner_u (.mclk(mclk), .rst_n(rst_n),
      .startLow(startLow), .evRnd(evRnd), .procReset(procReset),
      .syncStart_n(syncStart_n), .busEvent(busEvent), .extResetReq());
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   always @(posedge mclk) evRnd <= lfsr(evRnd);
   function automatic logic [23:0] bpExp(input logic [31:0] b, input logic s);
      logic [23:0] r;
      if (b[30] || s) r = b[23:0];
      else r = {4'h0, {2'b00, b[29:16], 4'h0} + {4'h0, b[15:0]}};
      if (b[31]) r[23:20] = HIGH_NIBBLE;
      return r;
   endfunction
   function automatic trace_t expTr(input trace_t e);
      trace_t t;
      t = e;
      if (e.coproc || e.cascade) t.valid = 1'b0;
      return t;
   endfunction
   task automatic chk(input string nm, input logic [31:0] got,
                      input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] v);
      @(posedge mclk);
      regAddr  <= ad;
      regWdata <= v;
      regWr    <= 1'b1;
      @(posedge mclk);
      regWr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad, output logic [31:0] v);
      @(posedge mclk);
      regAddr <= ad;
      regRd   <= 1'b1;
      @(posedge mclk);
      regRd   <= 1'b0;
      #1 v = regRdata;
   endtask
   task automatic setReg(input logic [3:0] ix, input logic [15:0] v);
      wr(ADDR_REGSEL, {28'h0, ix});
      wr(ADDR_REGDAT, {16'h0, v});
   endtask
   task automatic regChk(input logic [3:0] ix, input logic [15:0] v);
      wr(ADDR_REGSEL, {28'h0, ix});
      rd(ADDR_REGDAT, d);
      chk("buffer register", d[15:0], v);
   endtask
   // Counts the reset pulse and reload pulses that one command makes
   task automatic resetCmd(input logic [2:0] c);
      wr(ADDR_COMMAND, {29'h0, c});
      n = 0;
      m = 0;
      repeat (16) begin
         #1;
         if (softwareReload === 1'b1) m++;
         if (procReset === 1'b1) begin
            n++;
            chk("busOe in reset", {31'h0, busOe}, 32'h0);
         end
         @(posedge mclk);
      end
      chk("reset length", n, 32'hB);
      chk("extension reset", {31'h0, extensionReset}, 32'h0);
      chk("reload pulses", m, {31'h0, c == CMD_RESET_FULL});
   endtask
   task automatic summarize;
      $display("Checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ********************************************
   // Watchdog: whole sequence needs about 400 cycles
   // ********************************************
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      $display("Watchdog expired");
      summarize();
   end
   // ********************************************
   // Main sequence
   // ********************************************
   initial begin
      rnd = 32'hBA04BA6E;
      evRnd = 32'hBA04BA6E;
      {clkEn, regWr, regRd, startLow, rst_n} = 5'h10;
      regAddr = 8'h00;
      regWdata = 32'h0;
      error_cnt = 0;
      tests_run = 0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      #1 chk("reset pins", {procReset, procClk, busOe, hold, hlda}, 32'h10);
      for (n = 0; n < 40 && procReset !== 1'b0; n++) begin
         @(posedge mclk);
         #1;
      end
      chk("power-on reset", n, RESET_CYC + 1);
      a = procClk;
      for (i = 0; i < 4; i++) begin
         @(posedge mclk);
         #1 chk("half rate clock", {31'h0, procClk}, {31'h0, ~a});
         a = procClk;
      end
      rd(ADDR_STATUS, d);
      chk("high address flag", {31'h0, d[4]}, 32'h1);
      rd(ADDR_OPTIONS, d);
      chk("options default", d, 32'h1E);
      rd(8'h40, d);
      chk("unmapped read", d, 32'h0);
      $display("Test power-on done");
      setReg(R_AX, 16'h1234);
      setReg(R_STATUS_WORD, 16'h0001);
      resetCmd(CMD_RESET_UNIT);
      regChk(R_AX, 16'h1234);
      regChk(R_STATUS_WORD, 16'h0001);
      setReg(R_CS, 16'h0100);
      rd(ADDR_STATUS, d);
      chk("high address cleared", {31'h0, d[4]}, 32'h0);
      $display("Test unit reset done");
      // Protection flag left set in the status word on purpose
      for (i = 0; i < 12; i++) begin
         rnd = lfsr(rnd);
         bp = {rnd[31], 1'b0, rnd[29:0]};
         wr(ADDR_OPTIONS, {27'h0, OPT_DEFAULT[4:1], i[0]});
         wr(ADDR_BPIN, bp);
         rd(ADDR_BPOUT, d);
         chk("breakpoint address", d[23:0], bpExp(bp, i[0]));
      end
      wr(ADDR_OPTIONS, 32'h1E);
      wr(ADDR_BPIN, 32'h40FFFFF0);
      rd(ADDR_BPOUT, d);
      chk("absolute vector", d[23:0], RST_VECTOR);
      wr(ADDR_OPTIONS, 32'h1F);
      wr(ADDR_BPIN, 32'h40123456);
      rd(ADDR_BPOUT, d);
      chk("refused absolute", d[23:0], RST_VECTOR);
      rd(ADDR_STATUS, d);
      chk("refused flag", {31'h0, d[5]}, 32'h1);
      wr(ADDR_OPTIONS, 32'h1D);
      wr(ADDR_BPIN, 32'h40123456);
      rd(ADDR_BPOUT, d);
      chk("unchecked absolute", d[23:0], 24'h123456);
      $display("Test breakpoint done");
      resetCmd(CMD_RESET_REGS);
      regChk(R_CS, RST_CS);
      regChk(R_INSTR_PTR, RST_INSTR_PTR);
      regChk(R_STATUS_WORD, 16'h0000);
      regChk(R_AX, 16'h1234);
      resetCmd(CMD_RESET_FULL);
      rd(ADDR_OPTIONS, d);
      chk("options after full reset", d, 32'h1E);
      regChk(R_AX, RST_GP);
      regChk(R_SP, RST_GP);
      regChk(R_ES, 16'h0000);
      $display("Test register resets done");
      wr(ADDR_OPTIONS, 32'h06);
      setReg(R_AX, 16'hBEEF);
      startLow <= 1'b1;
      repeat (8) @(posedge mclk);
      wr(ADDR_COMMAND, {29'h0, CMD_GO});
      for (n = 0; n < 20 && hold !== 1'b1; n++) @(posedge mclk);
      #1 chk("hold only", {hold, hlda, busOe, fetchEnable}, 32'h8);
      repeat (10) @(posedge mclk);
      #1 chk("hold kept", {31'h0, hold}, 32'h1);
      startLow <= 1'b0;
      for (n = 0; n < 20 && hold !== 1'b0; n++) @(posedge mclk);
      for (n = 0; n < 40 && fetchEnable !== 1'b1; n++) @(posedge mclk);
      #1 chk("emulation runs", {hold, busOe, fetchEnable}, 32'h3);
      rd(ADDR_STATUS, d);
      chk("emulating", {31'h0, d[0]}, 32'h1);
      setReg(R_AX, 16'h5555);
      resetCmd(CMD_RESET_UNIT);
      rd(ADDR_STATUS, d);
      chk("forced break", {31'h0, d[0]}, 32'h0);
      regChk(R_AX, 16'hBEEF);
      $display("Test sync start done");
      setReg(R_AX, 16'h2468);
      wr(ADDR_COMMAND, {29'h0, CMD_GO});
      for (n = 0; n < 40 && fetchEnable !== 1'b1; n++) @(posedge mclk);
      chk("reload wait", n, NREG + 2);
      wr(ADDR_COMMAND, {29'h0, CMD_BREAK});
      rd(ADDR_STATUS, d);
      chk("break", {31'h0, d[0]}, 32'h0);
      regChk(R_AX, 16'h2468);
      $display("Test break done");
      @(posedge mclk);
      #1 prevEv = busEvent;
      repeat (40) begin
         @(posedge mclk);
         #1 chk("trace word", traceWord, expTr(prevEv));
         prevEv = busEvent;
      end
      @(posedge mclk);
      clkEn <= 1'b0;
      @(posedge mclk);
      #1 a = procClk;
      prevEv = traceWord;
      repeat (5) @(posedge mclk);
      #1 chk("frozen clock", {31'h0, procClk}, {31'h0, a});
      chk("frozen trace", traceWord, prevEv);
      clkEn <= 1'b1;
      $display("Test trace done");
      summarize();
   end
endmodule
